// ===== hw/nbh_pkg.sv
package nbh_pkg;
    // Bus operation kinds the host can issue
    typedef enum logic [2:0] {
        NBH_OP_CMD = 3'h0,
        NBH_OP_ADDR = 3'h1,
        NBH_OP_DIN = 3'h2,
        NBH_OP_DOUT = 3'h3,
        NBH_OP_ADDR4 = 3'h4
    } nbh_op_e;

    // Request from user logic
    typedef struct packed {
        nbh_op_e op;
        logic [15:0] data;
    } nbh_req_s;

    // Flash pin outputs driven by the host
    typedef struct packed {
        logic ceN;
        logic cmdLatchStrobe;
        logic addrLatchStrobe;
        logic weN;
        logic reN;
        logic wpN;
    } nbh_pins_s;

    // Bus timing in ns and derived cycles at the clock rate
    localparam int NBH_CLK_PS = 4000;
    localparam int NBH_STROBE_LOW_NS = 12;
    localparam int NBH_STROBE_HIGH_NS = 12;
    localparam int NBH_STROBE_LOW_CYC = (NBH_STROBE_LOW_NS * 1000 + NBH_CLK_PS - 1) / NBH_CLK_PS;
    localparam int NBH_STROBE_HIGH_CYC = (NBH_STROBE_HIGH_NS * 1000 + NBH_CLK_PS - 1)
        / NBH_CLK_PS;
    localparam logic [3:0] NBH_LOW_CNT = 4'(NBH_STROBE_LOW_CYC);
    localparam logic [3:0] NBH_HIGH_CNT = 4'(NBH_STROBE_HIGH_CYC);

    // Address field layout
    localparam int NBH_ADDR_W = 26;
    localparam int NBH_COL_LSB = 0;
    localparam int NBH_A8 = 8;
    localparam int NBH_B2_LSB = 9;
    localparam int NBH_B3_LSB = 17;
    localparam int NBH_A25 = 25;
    localparam logic [2:0] NBH_ADDR_CYCLES = 3'h4;
    localparam logic [7:0] NBH_CMD_PTR_A = 8'h00;
    localparam logic [7:0] NBH_CMD_PTR_B = 8'h01;
endpackage

// ===== hw/nbh_sync2.sv
`timescale 1ns/1ps
// Two-flop synchroniser for pin inputs
module nbh_sync2 #(
    parameter int W = 1
) (
    input wire logic clk, // Clock
    input wire logic rst_n, // Async reset
    input wire logic [W-1:0] async_i, // Pin level
    output logic [W-1:0] sync_o // Synchronised level
);
    logic [W-1:0] meta_q;

    // First flop only feeds the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule

// ===== hw/nbh_host.sv
`timescale 1ns/1ps
// What this block does
// - Command cycle: CE low, command strobe high, address strobe low, RE high, WE rises.
// - Commands use data lines 0-7 only; upper lanes ignored.
// - ADDR4 sends exactly four address cycles per address; ADDR sends a single one.
// - Address cycle: CE low, address strobe high, command strobe low, RE high, WE rises.
// - Data input: CE low, both strobes low, RE high; each WE rise one word.
// - Data output: CE low, WE high, strobes low; each RE fall next word.
// - Upper lanes carry data only in data input and output cycles.
// - Address bytes: A0-7, A9-16, A17-24, then A25 with seven zeros.
module nbh_host (
    input wire logic clk, // 250 MHz clock
    input wire logic rst_n, // Async reset, active low
    input wire nbh_pkg::nbh_req_s req, // Operation request
    input wire logic reqValid, // Request valid
    output logic reqReady, // Idle, can take a request
    input wire logic [25:0] addr, // Full address for ADDR4 op
    input wire logic writeProtect, // Protect request, high = protect
    input wire logic deselect, // Put device into standby
    output logic [15:0] rdData, // Word read from device
    output logic rdValid, // One-cycle pulse with rdData
    output logic devBusy, // Synchronised busy level
    output nbh_pkg::nbh_pins_s pins, // Flash strobes
    output logic [15:0] ioOut, // Data bus out
    output logic [15:0] ioOe, // Data bus drive enable per line
    input wire logic [15:0] ioIn, // Data bus in
    input wire logic ready_busy_n // Ready/busy pin, low = busy
);
    import nbh_pkg::*;

    // One-hot sequencer states; SAMPLE is only passed through on reads
    typedef enum logic [4:0] {
        NBH_IDLE = 5'h01,
        NBH_SETUP = 5'h02,
        NBH_LOW = 5'h04,
        NBH_HIGH = 5'h08,
        NBH_SAMPLE = 5'h10
    } nbh_st_e;

    // Sequencer state and the request it is working on
    nbh_st_e st_q;
    nbh_op_e op_q;
    logic [3:0] cnt_q;
    logic [2:0] addrIdx_q;
    logic [25:0] addr_q;
    logic [15:0] word_q;
    logic [15:0] ioSync;
    logic busySync;

    // Byte for a given address cycle
    function automatic logic [7:0] addrByte(input logic [25:0] a, input logic [2:0] i);
        case (i)
            3'h0: addrByte = a[NBH_COL_LSB +: 8];
            3'h1: addrByte = a[NBH_B2_LSB +: 8];
            3'h2: addrByte = a[NBH_B3_LSB +: 8];
            default: addrByte = {7'h00, a[NBH_A25]};
        endcase
    endfunction

    // Accept test shared by the sequencer and the ready flag. Codes outside the
    // five kinds are never taken, so an unlisted strobe mix cannot reach the pins.
    function automatic logic takeReq(input logic v, input logic d, input nbh_op_e o);
        case (o)
            NBH_OP_CMD, NBH_OP_ADDR, NBH_OP_DIN, NBH_OP_DOUT,
            NBH_OP_ADDR4: takeReq = v && !d;
            default: takeReq = 1'h0;
        endcase
    endfunction

    // Data lines pass two flops; read data is steady for the whole low phase
    nbh_sync2 #(.W(16)) u_sync_io (
        .clk(clk),
        .rst_n(rst_n),
        .async_i(ioIn),
        .sync_o(ioSync)
    );

    // Busy pin is open drain with a pull-up; inverted so high means busy
    nbh_sync2 #(.W(1)) u_sync_busy (
        .clk(clk),
        .rst_n(rst_n),
        .async_i(~ready_busy_n),
        .sync_o(busySync)
    );

    // Strobe sequencer; one bus cycle per request, four for ADDR4
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= NBH_IDLE;
            op_q <= NBH_OP_CMD;
            cnt_q <= 4'h0;
            addrIdx_q <= 3'h0;
            addr_q <= 26'h0;
            word_q <= 16'h0;
        end else begin
            case (st_q)
                NBH_IDLE: begin
                    if (takeReq(reqValid, deselect, req.op)) begin
                        op_q <= req.op;
                        word_q <= req.data;
                        addr_q <= addr;
                        addrIdx_q <= 3'h0;
                        st_q <= NBH_SETUP;
                    end
                end
                NBH_SETUP: begin
                    cnt_q <= NBH_LOW_CNT;
                    st_q <= NBH_LOW;
                end
                NBH_LOW: begin
                    if (cnt_q > 4'h1) begin
                        cnt_q <= cnt_q - 4'h1;
                    end else begin
                        cnt_q <= NBH_HIGH_CNT;
                        st_q <= (op_q == NBH_OP_DOUT) ? NBH_SAMPLE : NBH_HIGH;
                    end
                end
                NBH_SAMPLE: begin
                    st_q <= NBH_HIGH; // Data captured before RE rises
                end
                NBH_HIGH: begin
                    if (cnt_q > 4'h1) begin
                        cnt_q <= cnt_q - 4'h1;
                    end else if (op_q == NBH_OP_ADDR4 && addrIdx_q < NBH_ADDR_CYCLES - 3'h1) begin
                        addrIdx_q <= addrIdx_q + 3'h1;
                        st_q <= NBH_SETUP;
                    end else begin
                        st_q <= NBH_IDLE;
                    end
                end
                default: st_q <= NBH_IDLE;
            endcase
        end
    end

    // Strobe pins; write protect follows its input every cycle, never a strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pins <= '{ceN: 1'b1, cmdLatchStrobe: 1'b0, addrLatchStrobe: 1'b0,
                      weN: 1'b1, reN: 1'b1, wpN: 1'b0};
        end else begin
            pins.wpN <= ~writeProtect;
            pins.ceN <= deselect ? 1'b1 : (st_q == NBH_IDLE ? pins.ceN : 1'b0);
            // Only one latch strobe ever high, never both
            pins.cmdLatchStrobe <= (st_q != NBH_IDLE) && (op_q == NBH_OP_CMD);
            pins.addrLatchStrobe <= (st_q != NBH_IDLE)
                && (op_q == NBH_OP_ADDR || op_q == NBH_OP_ADDR4);
            pins.weN <= !(st_q == NBH_LOW && op_q != NBH_OP_DOUT);
            pins.reN <= !((st_q == NBH_LOW) && op_q == NBH_OP_DOUT);
        end
    end

    // Data lanes; set from the first cycle of a request and held past the
    // write strobe's rise, so the device latches a steady byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ioOut <= 16'h0;
            ioOe <= 16'h0;
        end else begin
            case (op_q)
                NBH_OP_CMD: begin
                    ioOut <= {8'h00, word_q[7:0]};
                    ioOe <= (st_q != NBH_IDLE) ? 16'h00ff : 16'h0000;
                end
                NBH_OP_ADDR: begin
                    ioOut <= {8'h00, word_q[7:0]};
                    ioOe <= (st_q != NBH_IDLE) ? 16'h00ff : 16'h0000;
                end
                NBH_OP_ADDR4: begin
                    ioOut <= {8'h00, addrByte(addr_q, addrIdx_q)};
                    ioOe <= (st_q != NBH_IDLE) ? 16'h00ff : 16'h0000;
                end
                NBH_OP_DIN: begin
                    ioOut <= word_q;
                    ioOe <= (st_q != NBH_IDLE) ? 16'hffff : 16'h0000;
                end
                default: begin
                    ioOut <= 16'h0;
                    ioOe <= 16'h0; // device drives
                end
            endcase
        end
    end

    // Read capture; synchronised lines lag the pins by two cycles, so the
    // device access time must fit inside the first cycle of the read strobe's low phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData <= 16'h0;
            rdValid <= 1'h0;
        end else begin
            rdValid <= (st_q == NBH_SAMPLE);
            if (st_q == NBH_SAMPLE) begin
                rdData <= ioSync;
            end
        end
    end

    // Ready means idle and not taking a request on this edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reqReady <= 1'h0;
        end else begin
            reqReady <= (st_q == NBH_IDLE) && !takeReq(reqValid, deselect, req.op);
        end
    end

    // Busy is only reported; the user waits for it to drop before a new command
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            devBusy <= 1'h0;
        end else begin
            devBusy <= busySync;
        end
    end
endmodule

// ===== tb/nbh_host_props.sv
`timescale 1ns/1ps
// Strobe and bus checks at the host pins
module nbh_host_props (
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset
    input wire logic deselect, // Standby
    input wire logic writeProtect, // Protect
    input wire logic rdValid, // Read done
    input wire logic [15:0] ioOe, // Bus enables
    input wire nbh_pkg::nbh_pins_s pins // Strobes
);
    import nbh_pkg::*;
    wire cmdOn = pins.cmdLatchStrobe;
    wire addrOn = pins.addrLatchStrobe;
    wire we = !pins.weN;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_oneLatch; !(cmdOn && addrOn); endproperty
    a_oneLatch: assert property (p_oneLatch) else $error("two latches");
    property p_weSel; we |-> !pins.ceN && pins.reN; endproperty
    a_weSel: assert property (p_weSel) else $error("write unselected");
    property p_addrBus; we && addrOn |-> ioOe[7:0] == 8'hff; endproperty
    a_addrBus: assert property (p_addrBus) else $error("addr undriven");
    property p_dinBus; we && !cmdOn && !addrOn |-> ioOe == 16'hffff; endproperty
    a_dinBus: assert property (p_dinBus) else $error("data undriven");
    property p_weLen; $fell(pins.weN) |-> we [*3] ##1 !we; endproperty
    a_weLen: assert property (p_weLen) else $error("write width");
    property p_rdBus;
        !pins.reN |-> !we && !cmdOn && !addrOn && !pins.ceN && ioOe == 16'h0;
    endproperty
    a_rdBus: assert property (p_rdBus) else $error("read conflict");
    property p_wpLive; $past(rst_n) |-> pins.wpN == !$past(writeProtect); endproperty
    a_wpLive: assert property (p_wpLive) else $error("protect lag");
    property p_stby; deselect |=> pins.ceN; endproperty
    a_stby: assert property (p_stby) else $error("not standby");
    // Main traffic kinds seen
    cover property (we && addrOn);
    cover property (rdValid);
    cover property (!pins.wpN && cmdOn);
endmodule
bind nbh_host nbh_host_props u_props (.clk, .rst_n, .deselect, .writeProtect, .rdValid,
    .ioOe, .pins);

// ===== tb/nbh_dev_model.sv
`timescale 1ns/1ps
// Small x16 device: one array word, pointer, status
module nbh_dev_model (
    input wire nbh_pkg::nbh_pins_s pins, // Strobes
    input wire logic [15:0] bus, // Resolved bus
    output logic [15:0] devDrv, // Device bus level
    output logic ready_busy_n = 1'b1 // Low = busy
);
    import nbh_pkg::*;
    wire cmdOn = pins.cmdLatchStrobe;
    wire addrOn = pins.addrLatchStrobe;
    wire outOn = !pins.ceN && pins.weN && !cmdOn && !addrOn;
    logic [7:0] cmdQ = 8'h00;
    logic [25:0] addrQ = '0;
    logic [2:0] nAddr = 3'h0;
    logic [15:0] arrWord = 16'h0, dinQ = 16'h0, dout = 16'h0;
    logic ptrB = 1'b0;
    // Released bus shows the inverse so stale data cannot pass
    assign devDrv = outOn ? dout : ~dout;
    // One process owns all state; a write strobe rise never meets a read strobe
    // fall, so the read strobe level tells the two events apart
    always @(posedge pins.weN or negedge pins.reN) begin
        if (!pins.reN) begin
            // Each read strobe fall presents the next word
            if (outOn) begin
                dout <= cmdQ == 8'h70 ? {8'h0, pins.wpN, 7'h0} : arrWord ^ {addrQ[15:9], ptrB,
                    addrQ[7:0]};
                if (cmdQ != 8'h70) ptrB <= 1'b0;
            end
        end else if (!pins.ceN) begin
            // Writes count only when selected with read strobe high
            if (cmdOn && !addrOn) begin
                cmdQ <= bus[7:0];
                nAddr <= 3'h0;
                if (bus[7:1] == 7'h0) ptrB <= bus[0];
                if (bus[7:0] == 8'h10 && pins.wpN) begin
                    arrWord <= dinQ;
                    fork begin ready_busy_n = 1'b0; #160; ready_busy_n = 1'b1; end join_none
                end
            end else if (addrOn && !cmdOn && nAddr < 3'h4) begin
                nAddr <= nAddr + 3'h1;
                case (nAddr)
                    3'h0: addrQ[7:0] <= bus[7:0];
                    3'h1: addrQ[16:9] <= bus[7:0];
                    3'h2: addrQ[24:17] <= bus[7:0];
                    default: addrQ[25] <= bus[0];
                endcase
            end else if (!addrOn && !cmdOn) dinQ <= bus;
        end
    end
endmodule

// ===== tb/test_nbh_host.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module test_nbh_host;
    import nbh_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, reqValid = 1'b0, writeProtect = 1'b0, deselect = 1'b0;
    logic reqReady, rdValid, devBusy, ready_busy_n, ptr, sawBusy;
    nbh_req_s req = '0;
    nbh_pins_s pins;
    logic [25:0] addr = '0;
    logic [15:0] rdData, ioOut, ioOe, ioIn, devDrv, got, mem = 16'h0, w;
    int n_mismatch = 0, checks = 0, seed = 32'h3cde, k, r;
    always #2 clk = ~clk;
    // Each line carries whichever side enables it
    assign ioIn = (ioOut & ioOe) | (devDrv & ~ioOe);
    nbh_host dut (.clk, .rst_n, .req, .reqValid, .reqReady, .addr, .writeProtect, .deselect,
        .rdData, .rdValid, .devBusy, .pins, .ioOut, .ioOe, .ioIn, .ready_busy_n);
    nbh_dev_model u_dev (.pins, .bus(ioIn), .devDrv, .ready_busy_n);
    function automatic logic [15:0] expRd(logic [15:0] m, logic [25:0] a, logic p);
        return m ^ {a[15:9], p, a[7:0]};
    endfunction
    task automatic give_verdict();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // One request, then wait for idle and a quiet device
    task automatic op(nbh_op_e o, logic [15:0] d);
        int i;
        req <= '{o, d};
        reqValid <= 1'b1;
        @(posedge clk);
        reqValid <= 1'b0;
        for (i = 0; i < 300 && (i < 12 || reqReady !== 1'b1 || devBusy !== 1'b0); i++) begin
            @(posedge clk);
            if (rdValid === 1'b1) got = rdData;
            if (devBusy === 1'b1) sawBusy = 1'b1;
        end
        if (i == 300) begin
            n_mismatch++;
            give_verdict();
        end
    endtask
    // Program then read back, protect on pairs 2, 3, 6 and 7
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (k = 0; k < 8; k++) begin
            r = $random(seed);
            w = r[15:0];
            ptr = r[16];
            writeProtect <= k[1];
            addr <= 26'($random(seed));
            op(NBH_OP_CMD, {r[31:24], 8'h80});
            op(NBH_OP_ADDR4, 16'h0);
            op(NBH_OP_DIN, w);
            sawBusy = 1'b0;
            op(NBH_OP_CMD, 16'h0010);
            `CHK(sawBusy, !k[1])
            if (!k[1]) mem = w;
            op(NBH_OP_CMD, {15'h0, ptr});
            addr <= 26'($random(seed));
            op(NBH_OP_ADDR4, 16'h0);
            if (k[0]) op(NBH_OP_ADDR, r[15:0]);
            op(NBH_OP_DOUT, 16'h0);
            `CHK(got, expRd(mem, addr, ptr))
            op(NBH_OP_CMD, 16'h0070);
            op(NBH_OP_DOUT, 16'h0);
            `CHK(got, {8'h0, !k[1], 7'h0})
        end
        deselect <= 1'b1;
        reqValid <= 1'b1;
        repeat (20) @(posedge clk);
        `CHK({pins.ceN, pins.weN, pins.reN}, 3'h7)
        give_verdict();
    end
endmodule
